// File: verilog/adsi_top.sv
// Decimation chain, gearbox packers and stream FIFOs for one tile
`timescale 1ns/10ps
module adsi_top
  import adsi_pkg::*;
#(
  parameter adsi_dec_t DEC_MODE = ADSI_DEC_1X,
  parameter bit        IQ_OUT   = 1'b0,
  parameter bit        TILE_2G  = 1'b0,
  parameter int        WORDS    = ADSI_WORDS,
  parameter int        FDEPTH   = ADSI_FDEPTH,
  parameter int        CLK_DIV  = ADSI_CLK_DIV,
  parameter int        FS_KHZ   = ADSI_FS_KHZ
) (
  input  wire logic                                clk,
  input  wire logic                                nrst,
  input  wire logic [ADSI_NCH-1:0]                 chan_enable,
  input  wire logic                                samp_valid,
  input  wire logic [ADSI_NCH-1:0][ADSI_SW-1:0]    adc_i,
  input  wire logic [ADSI_NCH-1:0][ADSI_SW-1:0]    adc_q,
  input  wire logic                                ovf_clear,
  input  wire logic                                tile_stream_clock_in,
  output logic [ADSI_NSTR-1:0][ADSI_TDW-1:0]
                                    adc_sample_stream_port_tdata,
  output logic [ADSI_NSTR-1:0]      adc_sample_stream_port_tvalid,
  input  wire logic [ADSI_NSTR-1:0] adc_sample_stream_port_tready,
  output logic                      tile_divided_sample_clock_out,
  output logic [ADSI_NSTR-1:0]      fifo_ovf,
  output logic [ADSI_NSTR-1:0]      fifo_marg,
  output logic [ADSI_NCH*ADSI_NCOMP*ADSI_NSTG-1:0] filt_ovf,
  output logic [1:0]                interleave_iq_factor,
  output logic [31:0]               req_stream_khz
);
  localparam int NCHN  = ADSI_NCH * ADSI_NCOMP;
  localparam int NS    = adsi_nstages(DEC_MODE);
  localparam int PW    = $clog2(FDEPTH);
  localparam int IL    = (TILE_2G && IQ_OUT) ? ADSI_IL_IQ2G : ADSI_IL_OTHER;
  localparam int DECF  = 1 << NS;
  localparam int REQ   = (FS_KHZ * IL) / (DECF * WORDS);
  localparam logic [PW:0] MTHR = (PW+1)'(FDEPTH - ADSI_MARGIN);
  localparam logic [PW:0] FULL = (PW+1)'(FDEPTH);
  localparam logic [ADSI_CNTW-1:0] WCNT = ADSI_CNTW'(WORDS);
  localparam logic [ADSI_CNTW-1:0] HDIV = ADSI_CNTW'(CLK_DIV / 2 - 1);

  // Rate figures the fabric must meet with its stream clock
  assign interleave_iq_factor = 2'(IL);
  assign req_stream_khz       = 32'(REQ);

  // ---------------- Divided, frequency-locked clock out
  logic [ADSI_CNTW-1:0] div_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r                         <= 4'h0;
      tile_divided_sample_clock_out <= 1'b0;
    end else if (div_r == HDIV) begin
      div_r                         <= 4'h0;
      tile_divided_sample_clock_out <= ~tile_divided_sample_clock_out;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // ---------------- Decimation chains, one per channel component
  logic                      cv [NCHN][ADSI_NSTG+1];
  logic signed [ADSI_SW-1:0] cd [NCHN][ADSI_NSTG+1];
  logic                      hv [NCHN][ADSI_NSTG];
  logic signed [ADSI_SW-1:0] hd [NCHN][ADSI_NSTG];
  logic [NCHN*ADSI_NSTG-1:0] ho;
  logic [NCHN*ADSI_NSTG-1:0] flt_r;

  for (genvar n = 0; n < NCHN; n++) begin : g_chain
    // Off mode and disabled channels feed nothing into the chain
    assign cv[n][0] = samp_valid && chan_enable[n/2] &&
                      (DEC_MODE != ADSI_DEC_OFF);
    assign cd[n][0] = (n % 2 == 1) ? adc_q[n/2] : adc_i[n/2];
    for (genvar s = 0; s < ADSI_NSTG; s++) begin : g_stg
      localparam bit USED = (NS > s) && (DEC_MODE != ADSI_DEC_OFF);
      adsi_halfband #(
        .STG       (s)
      ) u_hb (
        .clk       (clk),
        .nrst      (nrst),
        .en        (USED && chan_enable[n/2]),
        .in_valid  (cv[n][s]),
        .in_data   (cd[n][s]),
        .out_valid (hv[n][s]),
        .out_data  (hd[n][s]),
        .ovf       (ho[n*ADSI_NSTG+s])
      );
      // Unused stages are bypassed untouched
      assign cv[n][s+1] = USED ? hv[n][s] : cv[n][s];
      assign cd[n][s+1] = USED ? hd[n][s] : cd[n][s];
    end
  end

  // Sticky filter overflow; a new event beats the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt_r <= '0;
    end else begin
      flt_r <= (ovf_clear ? '0 : flt_r) | ho;
    end
  end
  assign filt_ovf = flt_r;

  // ---------------- Lane mapping of chain outputs onto streams
  logic [1:0]         lnum [ADSI_NSTR];
  logic [ADSI_SW-1:0] lw0  [ADSI_NSTR];
  logic [ADSI_SW-1:0] lw1  [ADSI_NSTR];

  always_comb begin
    for (int l = 0; l < ADSI_NSTR; l++) begin
      lnum[l] = 2'd0;
      lw0[l]  = cd[l][ADSI_NSTG];
      lw1[l]  = cd[(l/2)*2+1][ADSI_NSTG];
      if (!IQ_OUT) begin
        if (l % 2 == 0 && cv[l][ADSI_NSTG]) lnum[l] = 2'd1;
      end else if (!TILE_2G) begin
        // Even lanes carry in-phase, odd lanes quadrature
        if (cv[l][ADSI_NSTG]) lnum[l] = 2'd1;
      end else begin
        // I then Q of the same instant share one lane
        if (l % 2 == 0 && cv[l][ADSI_NSTG]) begin
          lnum[l] = 2'd2;
        end
      end
    end
  end

  // ---------------- Stream clock domain reset release
  logic srst1_r;
  logic srst_n_r;

  always_ff @(posedge tile_stream_clock_in or negedge nrst) begin
    if (!nrst) begin
      srst1_r  <= 1'b0;
      srst_n_r <= 1'b0;
    end else begin
      srst1_r  <= 1'b1;
      srst_n_r <= srst1_r;
    end
  end

  function automatic logic [PW:0] g2b(logic [PW:0] g);
    logic [PW:0] b;
    b[PW] = g[PW];
    for (int i = PW - 1; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  // ---------------- Per-lane gearbox packer and dual-clock FIFO
  // Lanes are built identically, so their latency matches
  for (genvar l = 0; l < ADSI_NSTR; l++) begin : g_lane
    logic [ADSI_TDW-1:0]  pack_r;
    logic [ADSI_CNTW-1:0] cnt_r;
    logic [ADSI_TDW-1:0]  wd;
    logic [ADSI_CNTW-1:0] cnt_sum;
    logic                 wr;
    logic [ADSI_TDW-1:0]  mem_r [FDEPTH];
    logic [PW:0]          wbin_r;
    logic [PW:0]          wgray_r;
    logic [PW:0]          rg1_r;
    logic [PW:0]          rg2_r;
    logic [PW:0]          fill;
    logic                 full;
    logic                 ovf_r;
    logic                 marg_r;
    logic [PW:0]          rbin_r;
    logic [PW:0]          rgray_r;
    logic [PW:0]          wg1_r;
    logic [PW:0]          wg2_r;
    logic                 empty;
    logic                 pop;
    logic [ADSI_TDW-1:0]  td_r;
    logic                 tv_r;

    // New words enter at the bottom: first word ends up highest
    always_comb begin
      cnt_sum = cnt_r + ADSI_CNTW'(lnum[l]);
      if (lnum[l] == 2'd2) begin
        wd = {pack_r[ADSI_TDW-2*ADSI_SW-1:0], lw0[l], lw1[l]};
      end else begin
        wd = {pack_r[ADSI_TDW-ADSI_SW-1:0], lw0[l]};
      end
      wr = (lnum[l] != 2'd0) && (cnt_sum >= WCNT);
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pack_r <= '0;
        cnt_r  <= 4'h0;
      end else if (wr) begin
        pack_r <= '0;
        cnt_r  <= 4'h0;
      end else if (lnum[l] != 2'd0) begin
        pack_r <= wd;
        cnt_r  <= cnt_sum;
      end
    end

    // Write side on the sample clock
    assign fill = wbin_r - g2b(rg2_r);
    assign full = (fill == FULL);

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        wbin_r  <= '0;
        wgray_r <= '0;
        rg1_r   <= '0;
        rg2_r   <= '0;
      end else begin
        rg1_r <= rgray_r;
        rg2_r <= rg1_r;
        if (wr && !full) begin
          wbin_r  <= wbin_r + 1'b1;
          wgray_r <= (wbin_r + 1'b1) ^ ((wbin_r + 1'b1) >> 1);
        end
      end
    end

    always_ff @(posedge clk) begin
      if (wr && !full) mem_r[wbin_r[PW-1:0]] <= wd;
    end

    // Overlap and near-overlap are sticky; set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ovf_r  <= 1'b0;
        marg_r <= 1'b0;
      end else begin
        ovf_r  <= (wr && full) ||
                  (ovf_r && !ovf_clear);
        marg_r <= (fill >= MTHR) ||
                  (marg_r && !ovf_clear);
      end
    end
    assign fifo_ovf[l]  = ovf_r;
    assign fifo_marg[l] = marg_r;

    // Read side on the fabric stream clock
    assign empty = (rgray_r == wg2_r);
    assign pop   = !empty && (!tv_r || adc_sample_stream_port_tready[l]);

    always_ff @(posedge tile_stream_clock_in or negedge srst_n_r) begin
      if (!srst_n_r) begin
        rbin_r  <= '0;
        rgray_r <= '0;
        wg1_r   <= '0;
        wg2_r   <= '0;
        tv_r    <= 1'b0;
        td_r    <= '0;
      end else begin
        wg1_r <= wgray_r;
        wg2_r <= wg1_r;
        if (pop) begin
          rbin_r  <= rbin_r + 1'b1;
          rgray_r <= (rbin_r + 1'b1) ^ ((rbin_r + 1'b1) >> 1);
          td_r    <= mem_r[rbin_r[PW-1:0]];
          tv_r    <= 1'b1;
        end else if (adc_sample_stream_port_tready[l]) begin
          tv_r <= 1'b0;
        end
      end
    end
    assign adc_sample_stream_port_tdata[l]  = td_r;
    assign adc_sample_stream_port_tvalid[l] = tv_r;
  end

  // Decimation is a build parameter; nothing here may retune it
  // at run time, as the stream bandwidth depends on it.
endmodule  // adsi_top

// File: verilog/adsi_pkg.sv
// Constants, types and coefficient tables for the ADC decimation streams
// Function
// - Disabled channel holds whole chain off
// - 1x passes samples through unfiltered
// - 2x/4x/8x decimate with 0.4 Fs passband
// - Three cascaded halving FIR stages
// - Fixed symmetric half-band coefficient tables
// - Up to eight 16-bit big-endian words per beat
// - Four stream masters, each with own FIFO
// - Fast tile I/Q: I even, Q odd streams
// - Slow tile I/Q: I/Q interleaved per stream
// - Words times stream clock equals output rate
// - Interleave factor two for slow I/Q only
// - Output clock divided from sample clock
// - FIFO overflow detected and raised as event
// - Report actual overflow on pointer overlap
// - Warn when pointers nearly overlap
// - Equal gearbox latency for all tile channels
// - Decimation fixed at build time
// - Stages used: one, two, three; rest off
// - Stage saturates, flags overflow, zero when unused
package adsi_pkg;
  localparam int ADSI_SW     = 16;
  localparam int ADSI_TDW    = 128;
  localparam int ADSI_NSTR   = 4;
  localparam int ADSI_NCH    = 2;
  localparam int ADSI_NCOMP  = 2;
  localparam int ADSI_NSTG   = 3;
  localparam int ADSI_ACW    = 40;
  localparam int ADSI_CNTW   = 4;
  localparam int ADSI_MARGIN = 2;
  localparam int ADSI_FDEPTH = 8;
  localparam int ADSI_WORDS  = 8;
  localparam int ADSI_CLK_DIV = 4;
  localparam int ADSI_FS_KHZ = 100000;
  localparam int ADSI_IL_IQ2G = 2;
  localparam int ADSI_IL_OTHER = 1;
  // Side taps per stage, listed outermost first, then the centre tap
  localparam int ADSI_NT [ADSI_NSTG] = '{10, 6, 4};
  localparam int ADSI_CSH [ADSI_NSTG] = '{17, 15, 12};
  localparam int ADSI_CA [11] = '{5, -17, -172, 44, -96, -4723, 187,
                                   -335, -13331, 41526, 65536};
  localparam int ADSI_CB [7] = '{-12, 84, -337, 1008, -2693, 10142, 16384};
  localparam int ADSI_CC [5] = '{-6, 54, -254, 1230, 2048};
  localparam logic signed [ADSI_ACW-1:0] ADSI_PMAX = 40'sh00_0000_7FFF;
  localparam logic signed [ADSI_ACW-1:0] ADSI_NMIN = 40'shFF_FFFF_8000;

  typedef enum logic [4:0] {
    ADSI_DEC_OFF = 5'h01,
    ADSI_DEC_1X  = 5'h02,
    ADSI_DEC_2X  = 5'h04,
    ADSI_DEC_4X  = 5'h08,
    ADSI_DEC_8X  = 5'h10
  } adsi_dec_t;

  function automatic int adsi_nstages(adsi_dec_t m);
    int n;
    n = 0;
    unique case (m)
      ADSI_DEC_OFF: n = 0;
      ADSI_DEC_1X:  n = 0;
      ADSI_DEC_2X:  n = 1;
      ADSI_DEC_4X:  n = 2;
      ADSI_DEC_8X:  n = 3;
    endcase
    return n;
  endfunction
endpackage

// File: verilog/adsi_halfband.sv
// One decimate-by-two half-band FIR stage with output saturation
`timescale 1ns/10ps
module adsi_halfband
  import adsi_pkg::*;
#(
  parameter int STG = 0
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     en,
  input  wire logic                     in_valid,
  input  wire logic signed [ADSI_SW-1:0] in_data,
  output logic                          out_valid,
  output logic signed [ADSI_SW-1:0]     out_data,
  output logic                          ovf
);
  localparam int NT  = ADSI_NT[STG];
  localparam int L   = 4 * NT - 1;
  localparam int MID = 2 * NT - 1;

  logic signed [ADSI_SW-1:0]  tap_r [L];
  logic                       phase_r;
  logic signed [ADSI_ACW-1:0] acc;
  logic signed [ADSI_ACW-1:0] scl;
  logic signed [ADSI_SW-1:0]  sat;
  logic                       hit;

  function automatic logic signed [ADSI_ACW-1:0] coef(int k);
    logic signed [ADSI_ACW-1:0] c;
    c = '0;
    case (STG)
      0:       c = ADSI_ACW'(ADSI_CA[k]);
      1:       c = ADSI_ACW'(ADSI_CB[k]);
      default: c = ADSI_ACW'(ADSI_CC[k]);
    endcase
    return c;
  endfunction

  // Symmetric pairs share one multiply; zero taps are skipped
  always_comb begin
    acc = coef(NT) * ADSI_ACW'(tap_r[MID]);
    for (int j = 0; j < NT; j++) begin
      acc = acc + coef(j) *
            (ADSI_ACW'(tap_r[MID - (2 * (NT - 1 - j) + 1)]) +
             ADSI_ACW'(tap_r[MID + (2 * (NT - 1 - j) + 1)]));
    end
    scl = acc >>> ADSI_CSH[STG];
    hit = (scl > ADSI_PMAX) || (scl < ADSI_NMIN);
    if (scl > ADSI_PMAX) begin
      sat = ADSI_PMAX[ADSI_SW-1:0];
    end else if (scl < ADSI_NMIN) begin
      sat = ADSI_NMIN[ADSI_SW-1:0];
    end else begin
      sat = scl[ADSI_SW-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < L; i++) tap_r[i] <= 16'h0000;
      phase_r <= 1'b0;
    end else if (!en) begin
      for (int i = 0; i < L; i++) tap_r[i] <= 16'h0000;
      phase_r <= 1'b0;
    end else if (in_valid) begin
      tap_r[0] <= in_data;
      for (int i = 1; i < L; i++) tap_r[i] <= tap_r[i-1];
      phase_r <= ~phase_r;
    end
  end

  // Every second input yields one output, halving the rate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
      ovf       <= 1'b0;
    end else if (!en) begin
      out_valid <= 1'b0;
      ovf       <= 1'b0;
    end else begin
      out_valid <= in_valid && phase_r;
      ovf       <= in_valid && phase_r && hit;
      if (in_valid && phase_r) out_data <= sat;
    end
  end
endmodule  // adsi_halfband

// File: tb/adsi_top_assertions.sv
// Port level assertions for the decimation stream block
`timescale 1ns/10ps
module adsi_top_assertions
  import adsi_pkg::*;
#(
  parameter adsi_dec_t DEC_MODE = ADSI_DEC_1X,
  parameter bit        IQ_OUT   = 1'b0,
  parameter bit        TILE_2G  = 1'b0,
  parameter int        WORDS    = ADSI_WORDS,
  parameter int        FS_KHZ   = ADSI_FS_KHZ
) (
  input wire logic                                clk,
  input wire logic                                nrst,
  input wire logic [ADSI_NCH-1:0]                 chan_enable,
  input wire logic                                samp_valid,
  input wire logic [ADSI_NCH-1:0][ADSI_SW-1:0]    adc_i,
  input wire logic [ADSI_NCH-1:0][ADSI_SW-1:0]    adc_q,
  input wire logic                                ovf_clear,
  input wire logic                                tile_stream_clock_in,
  input wire logic [ADSI_NSTR-1:0][ADSI_TDW-1:0]  adc_sample_stream_port_tdata,
  input wire logic [ADSI_NSTR-1:0]                adc_sample_stream_port_tvalid,
  input wire logic [ADSI_NSTR-1:0]                adc_sample_stream_port_tready,
  input wire logic                                tile_divided_sample_clock_out,
  input wire logic [ADSI_NSTR-1:0]                fifo_ovf,
  input wire logic [ADSI_NSTR-1:0]                fifo_marg,
  input wire logic [ADSI_NCH*ADSI_NCOMP*ADSI_NSTG-1:0] filt_ovf,
  input wire logic [1:0]                          interleave_iq_factor,
  input wire logic [31:0]                         req_stream_khz
);
  localparam int DECF = 1 << adsi_nstages(DEC_MODE);
  localparam int IL = (TILE_2G && IQ_OUT) ? ADSI_IL_IQ2G : ADSI_IL_OTHER;

  AST_FILT_UNUSED: assert property (@(posedge clk) disable iff (!nrst)
    (adsi_nstages(DEC_MODE) == 0) |-> filt_ovf == '0)
    else $error("stage flag set while stages unused");
  AST_IL_FACTOR: assert property (@(posedge clk) disable iff (!nrst)
    interleave_iq_factor == 2'(IL))
    else $error("interleave factor wrong");
  AST_RATE: assert property (@(posedge clk) disable iff (!nrst)
    req_stream_khz * WORDS * DECF == FS_KHZ * IL)
    else $error("stream rate does not balance output rate");
  AST_DIVCLK: assert property (@(posedge clk) disable iff (!nrst)
    $rose(tile_divided_sample_clock_out) |=> tile_divided_sample_clock_out
    ##1 !tile_divided_sample_clock_out ##1 !tile_divided_sample_clock_out
    ##1 tile_divided_sample_clock_out)
    else $error("divided clock period wrong");
  AST_OVF_STICKY: assert property (@(posedge clk) disable iff (!nrst)
    !$past(ovf_clear) |-> (fifo_ovf & $past(fifo_ovf)) == $past(fifo_ovf))
    else $error("overflow flag dropped without clear");
  AST_MARG_STICKY: assert property (@(posedge clk) disable iff (!nrst)
    !$past(ovf_clear) |-> (fifo_marg & $past(fifo_marg)) == $past(fifo_marg))
    else $error("marginal flag dropped without clear");
  AST_OVF_MARG: assert property (@(posedge clk) disable iff (!nrst)
    (fifo_ovf & ~fifo_marg) == '0)
    else $error("overflow without marginal warning");
  AST_ODD_IDLE: assert property (@(posedge tile_stream_clock_in)
    disable iff (!nrst) !IQ_OUT |-> !adc_sample_stream_port_tvalid[1]
    && !adc_sample_stream_port_tvalid[3])
    else $error("odd stream active in real mode");
  for (genvar s = 0; s < ADSI_NSTR; s++) begin : g_str
    AST_HOLD: assert property (@(posedge tile_stream_clock_in)
      disable iff (!nrst) adc_sample_stream_port_tvalid[s]
      && !adc_sample_stream_port_tready[s] |=> adc_sample_stream_port_tvalid[s]
      && $stable(adc_sample_stream_port_tdata[s]))
      else $error("beat changed before accept");
    AST_UPPER_ZERO: assert property (@(posedge tile_stream_clock_in)
      disable iff (!nrst) adc_sample_stream_port_tvalid[s]
      |-> (adc_sample_stream_port_tdata[s] >> (WORDS * 16)) == '0)
      else $error("unused upper beat bits not zero");
  end
endmodule // adsi_top_assertions

bind adsi_top adsi_top_assertions #(.DEC_MODE(DEC_MODE), .IQ_OUT(IQ_OUT),
  .TILE_2G(TILE_2G), .WORDS(WORDS), .FS_KHZ(FS_KHZ)) u_chk (
  .clk(clk), .nrst(nrst), .chan_enable(chan_enable),
  .samp_valid(samp_valid), .adc_i(adc_i), .adc_q(adc_q),
  .ovf_clear(ovf_clear), .tile_stream_clock_in(tile_stream_clock_in),
  .adc_sample_stream_port_tdata(adc_sample_stream_port_tdata),
  .adc_sample_stream_port_tvalid(adc_sample_stream_port_tvalid),
  .adc_sample_stream_port_tready(adc_sample_stream_port_tready),
  .tile_divided_sample_clock_out(tile_divided_sample_clock_out),
  .fifo_ovf(fifo_ovf), .fifo_marg(fifo_marg), .filt_ovf(filt_ovf),
  .interleave_iq_factor(interleave_iq_factor),
  .req_stream_khz(req_stream_khz));

// File: tb/adsi_fabric_model.sv
// Fabric side stream consumer with prompt, random or stalled ready
`timescale 1ns/10ps
module adsi_fabric_model
  import adsi_pkg::*;
(
  input  wire logic                               sclk,
  input  wire logic                               nrst,
  input  wire logic                               stall,
  input  wire logic                               slow,
  input  wire logic [ADSI_NSTR-1:0][ADSI_TDW-1:0] tdata,
  input  wire logic [ADSI_NSTR-1:0]               tvalid,
  output logic [ADSI_NSTR-1:0]                    tready
);
  logic [ADSI_TDW-1:0] got [ADSI_NSTR][$];

  // All four streams consumed on the one stream clock
  always @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      tready <= '0;
    end else begin
      for (int s = 0; s < ADSI_NSTR; s++) begin
        if (tvalid[s] && tready[s]) begin
          got[s].push_back(tdata[s]);
        end
      end
      tready <= stall ? '0 : (slow ? 4'($urandom) : '1);
    end
  end
endmodule // adsi_fabric_model

// File: tb/adc_decimation_stream_interface_test.sv
// Self-checking bench for the decimation stream block in bypass, real mode
`timescale 1ns/10ps
module adc_decimation_stream_interface_test;
  import adsi_pkg::*;
  localparam int WORDS = 2;
  logic                               clk = 1'b0;
  logic                               sclk, nrst, sv, clr, stall, slow, dclk;
  logic                               prev;
  logic [ADSI_NCH-1:0]                en;
  logic [ADSI_NCH-1:0][ADSI_SW-1:0]   ai, aq;
  logic [ADSI_NSTR-1:0][ADSI_TDW-1:0] td;
  logic [ADSI_NSTR-1:0]               tv, tr, fovf, fmarg;
  logic [11:0]                        filt;
  logic [1:0]                         ilf;
  logic [31:0]                        rkhz;
  logic [ADSI_TDW-1:0]                expq [ADSI_NSTR][$];
  logic [ADSI_SW-1:0]                 pend [ADSI_NCH][$];
  int                                 mismatches, total_checks, cycles, n;

  always #5 clk = ~clk;
  initial begin
    sclk = 1'b0;
    #3.3;
    forever #7.5 sclk = ~sclk;
  end

  adsi_top #(.DEC_MODE(ADSI_DEC_1X), .IQ_OUT(1'b0), .TILE_2G(1'b0),
    .WORDS(WORDS)) dut (
    .clk(clk), .nrst(nrst), .chan_enable(en), .samp_valid(sv),
    .adc_i(ai), .adc_q(aq), .ovf_clear(clr), .tile_stream_clock_in(sclk),
    .adc_sample_stream_port_tdata(td), .adc_sample_stream_port_tvalid(tv),
    .adc_sample_stream_port_tready(tr),
    .tile_divided_sample_clock_out(dclk), .fifo_ovf(fovf),
    .fifo_marg(fmarg), .filt_ovf(filt), .interleave_iq_factor(ilf),
    .req_stream_khz(rkhz));

  adsi_fabric_model fab (.sclk(sclk), .nrst(nrst), .stall(stall),
    .slow(slow), .tdata(td), .tvalid(tv), .tready(tr));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Drives samples; pads with samples, valid at random when not dense, until every packer holds whole beats
  task automatic feed(input int cnt, input bit dense);
    logic [ADSI_TDW-1:0] b;
    for (int k = 0; k < cnt || pend[0].size() + pend[1].size() > 0; k++) begin
      @(negedge clk);
      sv = dense || ($urandom_range(3) != 0);
      ai = $urandom;
      aq = $urandom;
      for (int c = 0; c < ADSI_NCH; c++) begin
        if (sv && en[c]) begin
          pend[c].push_back(ai[c]);
          if (pend[c].size() == WORDS) begin
            b = '0;
            while (pend[c].size() > 0) b = (b << 16) | 128'(pend[c].pop_front());
            expq[2*c].push_back(b);
          end
        end
      end
    end
    @(negedge clk);
    sv = 1'b0;
  endtask

  task automatic drain(input string name);
    for (int t = 0; t < 300; t++) begin
      @(posedge clk);
      for (int s = 0; s < ADSI_NSTR; s++) begin
        while (fab.got[s].size() > 0 && expq[s].size() > 0) begin
          check(fab.got[s].pop_front(), expq[s].pop_front(), "beat");
        end
      end
    end
    for (int s = 0; s < ADSI_NSTR; s++) begin
      check(128'(expq[s].size()), 128'h0, "missing beats");
      check(128'(fab.got[s].size()), 128'h0, "extra beats");
    end
    // Hand back on a falling edge so the next inputs change off the edge
    @(negedge clk);
    $display("test %s done", name);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  initial begin
    void'($urandom(32'hC4E9967C));
    {nrst, en, sv, clr, stall, slow} = '0;
    ai = '0;
    aq = '0;
    repeat (5) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (10) @(negedge clk);
    check(128'(ilf), 128'h1, "factor");
    check(128'(rkhz), 128'hC350, "rate");
    check(128'(filt), 128'h0, "stage flags");
    check(128'({fovf, fmarg}), 128'h0, "fifo flags");
    prev = dclk;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (dclk && !prev) n++;
      prev = dclk;
    end
    check(128'(n), 128'hA, "divided clock rises");
    $display("test constants done");
    en = 2'h3;
    feed(40, 1'b1);
    drain("both channels");
    slow = 1'b1;
    en = 2'h2;
    feed(40, 1'b0);
    drain("slow fabric one channel");
    en = 2'h0;
    feed(20, 1'b0);
    drain("channels off");
    slow = 1'b0;
    stall = 1'b1;
    en = 2'h1;
    feed(8, 1'b1);
    repeat (20) @(negedge clk);
    check(128'({fovf, fmarg}), 128'h0, "flags at four beats");
    feed(6, 1'b1);
    repeat (20) @(negedge clk);
    check(128'({fovf, fmarg}), 128'h01, "near full");
    feed(30, 1'b1);
    repeat (40) @(negedge clk);
    check(128'({fovf, fmarg}), 128'h11, "overflow");
    stall = 1'b0;
    repeat (100) @(negedge clk);
    check(128'({fovf, fmarg}), 128'h11, "flags held");
    clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    repeat (3) @(negedge clk);
    check(128'({fovf, fmarg}), 128'h0, "flags cleared");
    for (int s = 0; s < ADSI_NSTR; s++) begin
      fab.got[s].delete();
      expq[s].delete();
    end
    feed(8, 1'b1);
    drain("overflow and recovery");
    tally_and_finish;
  end
endmodule // adc_decimation_stream_interface_test
